// >>> rtl/prio_regs_defines.svh
`ifndef PRIO_REGS_DEFINES_SVH
`define PRIO_REGS_DEFINES_SVH
// Summary of operation
// - A three-bit field value 111 gives its source level 7, the highest.
// - Value 001 gives level 1, the lowest enabled; codes between map linearly.
// - Value 000 disables the source so it never requests service.
// - Every implemented field resets to binary 100, level 4.
// - Unimplemented bits read zero and ignore writes.
// - Implemented field bits are read/write and return the last value written.
// - First register: serial event at 6-4, serial fault at 2-0.
// - Second register: capture 5 at 14-12, capture 4 at 10-8, capture 3 at 6-4.
// - Third: compare 7 14-12, compare 6 10-8, compare 5 6-4, capture 6 2-0.
// - On the reduced-pin variant the parallel port field is absent.
// - Fifth: two-wire master at 10-8, two-wire slave at 6-4.

// ==========================================================
// Register byte addresses
`define PRIO_ADDR_8  12'h000
`define PRIO_ADDR_9  12'h004
`define PRIO_ADDR_10 12'h008
`define PRIO_ADDR_11 12'h00C
`define PRIO_ADDR_12 12'h010
`define PRIO_ADDR_13 12'h014

// ==========================================================
// Field positions (low bit of each three-bit field)
`define FIELD_HI 12
`define FIELD_MH 8
`define FIELD_ML 4
`define FIELD_LO 0

// ==========================================================
// Reset value and disabled code
`define PRIO_RESET 3'h4
`define PRIO_OFF   3'h0
`define READ_ZERO  32'h0000_0000
`define IMAGE_ZERO 16'h0000
`endif

// >>> rtl/prio_regs_pkg.sv
package prio_regs_pkg;
  typedef logic [2:0] prio_t;

  typedef struct packed {
    prio_t serial_periph2_event_prio;
    prio_t serial_periph2_fault_prio;
    prio_t capture5_prio;
    prio_t capture4_prio;
    prio_t capture3_prio;
    prio_t compare7_prio;
    prio_t compare6_prio;
    prio_t compare5_prio;
    prio_t capture6_prio;
    prio_t parallel_port_prio;
    prio_t compare8_prio;
    prio_t twowire2_master_prio;
    prio_t twowire2_slave_prio;
    prio_t ext_irq4_prio;
    prio_t ext_irq3_prio;
  } prio_fields_s;
endpackage

// >>> rtl/interrupt_priority_regs.sv
// Chosen here: the address map and the APB interface to the registers.
`include "prio_regs_defines.svh"

module interrupt_priority_regs #(
  parameter bit HAS_PARALLEL_PORT = 1'b1
) (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Priority levels to the arbitration logic
  output prio_regs_pkg::prio_fields_s     prio
);
  import prio_regs_pkg::*;

  // ==========================================================
  // Internal signals
  prio_fields_s next_prio;
  logic [31:0]  next_prdata;
  logic         next_pslverr;
  logic         next_pready;
  logic         setup;
  logic         access;
  logic         wr_lo;
  logic         wr_hi;
  logic         hit;
  logic         sel_8;
  logic         sel_9;
  logic         sel_10;
  logic         sel_11;
  logic         sel_12;
  logic         sel_13;
  logic [15:0]  image_8;
  logic [15:0]  image_9;
  logic [15:0]  image_10;
  logic [15:0]  image_11;
  logic [15:0]  image_12;
  logic [15:0]  image_13;
  logic [15:0]  read_word;

  // ==========================================================
  // Bus phases
  // A transfer is taken in its setup cycle; the answer stands in the
  // access cycle, and a write lands at the edge that closes it
  assign setup  = psel && !penable;
  assign access = psel && penable && pready;
  assign wr_lo  = access && pwrite && pstrb[0];
  assign wr_hi  = access && pwrite && pstrb[1];

  // ==========================================================
  // Address decode
  // Only exact word addresses match; anything else is refused
  always_comb begin
    sel_8  = (paddr == `PRIO_ADDR_8);
    sel_9  = (paddr == `PRIO_ADDR_9);
    sel_10 = (paddr == `PRIO_ADDR_10);
    sel_11 = (paddr == `PRIO_ADDR_11);
    sel_12 = (paddr == `PRIO_ADDR_12);
    sel_13 = (paddr == `PRIO_ADDR_13);
    hit    = sel_8 || sel_9 || sel_10 ||
             sel_11 || sel_12 || sel_13;
  end

  // ==========================================================
  // Register images
  // Unimplemented positions are tied to zero here, so they read
  // zero and a write to them has nowhere to land
  always_comb begin
    image_8                 = `IMAGE_ZERO;
    image_8[`FIELD_ML +: 3] = prio.serial_periph2_event_prio;
    image_8[`FIELD_LO +: 3] = prio.serial_periph2_fault_prio;
  end

  always_comb begin
    image_9                 = `IMAGE_ZERO;
    image_9[`FIELD_HI +: 3] = prio.capture5_prio;
    image_9[`FIELD_MH +: 3] = prio.capture4_prio;
    image_9[`FIELD_ML +: 3] = prio.capture3_prio;
  end

  always_comb begin
    image_10                 = `IMAGE_ZERO;
    image_10[`FIELD_HI +: 3] = prio.compare7_prio;
    image_10[`FIELD_MH +: 3] = prio.compare6_prio;
    image_10[`FIELD_ML +: 3] = prio.compare5_prio;
    image_10[`FIELD_LO +: 3] = prio.capture6_prio;
  end

  // The parallel port field only exists on the full-pin variant
  always_comb begin
    image_11 = `IMAGE_ZERO;
    if (HAS_PARALLEL_PORT) begin
      image_11[`FIELD_ML +: 3] = prio.parallel_port_prio;
    end
    image_11[`FIELD_LO +: 3] = prio.compare8_prio;
  end

  always_comb begin
    image_12                 = `IMAGE_ZERO;
    image_12[`FIELD_MH +: 3] = prio.twowire2_master_prio;
    image_12[`FIELD_ML +: 3] = prio.twowire2_slave_prio;
  end

  always_comb begin
    image_13                 = `IMAGE_ZERO;
    image_13[`FIELD_MH +: 3] = prio.ext_irq4_prio;
    image_13[`FIELD_ML +: 3] = prio.ext_irq3_prio;
  end

  // ==========================================================
  // Field write path
  // Each byte lane updates only the fields that lie inside it
  always_comb begin
    next_prio = prio;
    if (wr_lo) begin
      if (sel_8) begin
        next_prio.serial_periph2_event_prio = pwdata[`FIELD_ML +: 3];
        next_prio.serial_periph2_fault_prio = pwdata[`FIELD_LO +: 3];
      end
      if (sel_9) begin
        next_prio.capture3_prio = pwdata[`FIELD_ML +: 3];
      end
      if (sel_10) begin
        next_prio.compare5_prio = pwdata[`FIELD_ML +: 3];
        next_prio.capture6_prio = pwdata[`FIELD_LO +: 3];
      end
      if (sel_11) begin
        if (HAS_PARALLEL_PORT) begin
          next_prio.parallel_port_prio = pwdata[`FIELD_ML +: 3];
        end
        next_prio.compare8_prio = pwdata[`FIELD_LO +: 3];
      end
      if (sel_12) begin
        next_prio.twowire2_slave_prio = pwdata[`FIELD_ML +: 3];
      end
      if (sel_13) begin
        next_prio.ext_irq3_prio = pwdata[`FIELD_ML +: 3];
      end
    end
    if (wr_hi) begin
      if (sel_9) begin
        next_prio.capture5_prio = pwdata[`FIELD_HI +: 3];
        next_prio.capture4_prio = pwdata[`FIELD_MH +: 3];
      end
      if (sel_10) begin
        next_prio.compare7_prio = pwdata[`FIELD_HI +: 3];
        next_prio.compare6_prio = pwdata[`FIELD_MH +: 3];
      end
      if (sel_12) begin
        next_prio.twowire2_master_prio = pwdata[`FIELD_MH +: 3];
      end
      if (sel_13) begin
        next_prio.ext_irq4_prio = pwdata[`FIELD_MH +: 3];
      end
    end
  end

  // ==========================================================
  // Read select
  // The selects are exclusive, so at most one image is taken
  always_comb begin
    read_word = `IMAGE_ZERO;
    if (sel_8) begin
      read_word = image_8;
    end
    if (sel_9) begin
      read_word = image_9;
    end
    if (sel_10) begin
      read_word = image_10;
    end
    if (sel_11) begin
      read_word = image_11;
    end
    if (sel_12) begin
      read_word = image_12;
    end
    if (sel_13) begin
      read_word = image_13;
    end
  end

  // ==========================================================
  // Bus answer
  // Registered in the setup cycle so that it stands for the whole
  // access cycle; refused transfers answer zero with an error
  always_comb begin
    next_prdata  = `READ_ZERO;
    next_pslverr = 1'b0;
    next_pready  = setup;
    if (setup) begin
      next_pslverr = !hit;
      if (!pwrite && hit) begin
        next_prdata = {`IMAGE_ZERO, read_word};
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio <= '{default: `PRIO_RESET};
      if (!HAS_PARALLEL_PORT) begin
        prio.parallel_port_prio <= `PRIO_OFF;
      end
      prdata  <= `READ_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Levels pass unchanged: 0 disables, 1..7 rank upward
      prio    <= next_prio;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end
endmodule

// >>> tb/prio_regs_monitor.sv
module prio_regs_monitor (
  // Clock and reset
  input wire logic                        pclk,
  input wire logic                        presetn,
  // APB
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [11:0]                 paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [3:0]                  pstrb,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  // Levels
  input wire prio_regs_pkg::prio_fields_s prio
);
  timeunit 1ns;
  timeprecision 1ps;
  import prio_regs_pkg::*;
  wire logic rd = pready && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Bus and layout
  a_ready_access: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_unused_zero: assert property (pready |-> prdata[31:15] == 0 &&
    !prdata[11] && !prdata[7] && !prdata[3]) else $error("unused bit set");
  a_err_read: assert property (pslverr |-> pready && prdata == 0)
    else $error("error with data");
  a_reg8_read: assert property (rd && paddr == 12'h000 |-> prdata ==
    {25'h0, prio.serial_periph2_event_prio, 1'b0,
     prio.serial_periph2_fault_prio}) else $error("reg8 layout");
  a_reg9_read: assert property (rd && paddr == 12'h004 |-> prdata ==
    {17'h0, prio.capture5_prio, 1'b0, prio.capture4_prio, 1'b0,
     prio.capture3_prio, 4'h0}) else $error("reg9 layout");
  a_reg10_read: assert property (rd && paddr == 12'h008 |-> prdata ==
    {17'h0, prio.compare7_prio, 1'b0, prio.compare6_prio, 1'b0,
     prio.compare5_prio, 1'b0, prio.capture6_prio}) else $error("reg10");
  a_reg11_read: assert property (rd && paddr == 12'h00C |-> prdata ==
    {25'h0, prio.parallel_port_prio, 1'b0, prio.compare8_prio})
    else $error("reg11 layout");
  a_reg12_read: assert property (rd && paddr == 12'h010 |-> prdata ==
    {21'h0, prio.twowire2_master_prio, 1'b0, prio.twowire2_slave_prio, 4'h0})
    else $error("reg12 layout");
  a_reg13_read: assert property (rd && paddr == 12'h014 |-> prdata ==
    {21'h0, prio.ext_irq4_prio, 1'b0, prio.ext_irq3_prio, 4'h0})
    else $error("reg13 layout");
  a_prio_hold: assert property (!(psel && penable && pready && pwrite) |=>
    $stable(prio)) else $error("level changed without write");
endmodule
bind interrupt_priority_regs prio_regs_monitor prio_regs_monitor_inst (.*);

// >>> tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import prio_regs_pkg::*;
  `define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
    $display("MISMATCH %0t %h %h", $time, a, b); end end
  localparam logic [15:0] MASK [6] = '{16'h0077, 16'h7770, 16'h7777,
                                       16'h0077, 16'h0770, 16'h0770};
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, r;
  logic [3:0]   pstrb;
  prio_fields_s prio;
  logic [15:0]  sh [6];
  int           fail_count, n_tests, cyc;
  interrupt_priority_regs interrupt_priority_regs_inst (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .prio);
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic prio_fields_s exp_prio();
    return {sh[0][6:4], sh[0][2:0], sh[1][14:12], sh[1][10:8], sh[1][6:4],
      sh[2][14:12], sh[2][10:8], sh[2][6:4], sh[2][2:0], sh[3][6:4],
      sh[3][2:0], sh[4][10:8], sh[4][6:4], sh[5][10:8], sh[5][6:4]};
  endfunction
  task automatic op(input logic w, input int i, input logic [31:0] d,
                    input logic [3:0] s);
    logic [15:0] lm;
    lm = {{8{s[1]}}, {8{s[0]}}};
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= 12'(i * 4);
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    `CHK(pslverr, 1'(i > 5))
    if (!w || i > 5) `CHK(prdata, i > 5 ? 32'h0 : {16'h0, sh[i]})
    if (w && i < 6) sh[i] = (sh[i] & ~lm | d[15:0] & lm) & MASK[i];
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    `CHK(prio, exp_prio())
  endtask
  task report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // Clock, timeout, sequence
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    r = 32'h8245;
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    for (int i = 0; i < 6; i++) sh[i] = MASK[i] & 16'h4444;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(prio, {15{3'h4}})
    for (int i = 0; i < 6; i++) op(1'b0, i, 32'h0, 4'h0);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      for (int i = 0; i < 8; i++) begin
        op(1'b1, i, {8{1'b1, 3'(c)}}, 4'h3);
        op(1'b0, i, 32'h0, 4'h0);
      end
    end
    $display("test codes done");
    repeat (300) begin
      r = lfsr(r);
      op(r[0], int'(r[3:1]), lfsr(r), r[7:4]);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    $display("test random done");
    report_and_stop();
  end
endmodule
